/* pfpc_pkg.sv */
// shared constants and carrier types for port function and pad control
package pfpc_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_PULLUP_EN   = 8'h0c;
  localparam logic [7:0] IDX_DRIVE_STR   = 8'h0d;
  localparam logic [7:0] IDX_WIN_BASE    = 8'h11;
  localparam logic [7:0] IDX_J_PULL_SEL  = 8'h2d;
  localparam logic [7:0] IDX_J_PULL_EN   = 8'h2e;
  localparam logic [7:0] IDX_MODE_CTRL   = 8'h30;
  localparam logic [7:0] IDX_KWU_EN_D    = 8'h32;
  localparam logic [7:0] IDX_KWU_EN_H    = 8'h33;
  localparam logic [7:0] IDX_KWU_EN_J    = 8'h34;
  localparam logic [7:0] IDX_KWU_FLAG_D  = 8'h35;
  localparam logic [7:0] IDX_KWU_FLAG_H  = 8'h36;
  localparam logic [7:0] IDX_KWU_FLAG_J  = 8'h37;

  // reset values
  localparam logic [7:0] RST_PULLUP_EN   = 8'hff;
  localparam logic [7:0] RST_DRIVE_STR   = 8'h00;
  localparam logic [7:0] RST_J_PULL_SEL  = 8'h00;
  localparam logic [7:0] RST_J_PULL_EN   = 8'h00;
  localparam logic [4:0] RST_WIN_BASE    = 5'h00;
  localparam logic [2:0] RST_MODE_CTRL   = 3'h0;

  // mode control field positions
  localparam int MODE_EXPANDED = 0;
  localparam int MODE_WIDE     = 1;
  localparam int MODE_QTRACK   = 2;

  // window base field sits in bits 7:3 of its register
  localparam int WIN_FIELD_LSB = 3;
  // window geometry: 2-Kbyte region, first 512 bytes decoded
  localparam int WIN_REGION_BYTES = 2048;
  localparam int WIN_DECODE_BYTES = 512;

  // port e bit positions with special use
  localparam int PE_NMI    = 0;
  localparam int PE_MI     = 1;
  localparam int PE_STROBE = 3;
  localparam int PE_BCLK   = 4;
  localparam int PE_MODE_A = 5;
  localparam int PE_MODE_B = 6;

  // one eight-bit pad: drive value and output enable
  typedef struct packed {
    logic [7:0] o;
    logic [7:0] oe;
  } pfpc_pad_t;

  // access presented to the register window decoder
  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
  } pfpc_acc_t;

  // decoder answer
  typedef struct packed {
    logic       hit;
    logic       mem;
    logic [8:0] offset;
  } pfpc_win_t;

endpackage

/* pfpc_win_dec.sv */
// register window decoder: relocatable 2-Kbyte region, 512-byte window
`timescale 1ns/1ps
module pfpc_win_dec
  import pfpc_pkg::*;
(
  // clock and reset
  input  wire logic      core_clk,
  input  wire logic      rstn,
  // window base and access
  input  wire logic [4:0] base,
  input  wire pfpc_acc_t acc,
  // registered decode result
  output pfpc_win_t      win
);

  typedef struct packed {
    pfpc_win_t win;
  } pfpc_dec_st_t;

  pfpc_dec_st_t st_q;
  pfpc_dec_st_t st_d;
  logic         in_region;
  logic         in_window;

  // upper five address bits select the region
  assign in_region = acc.valid && (acc.addr[15:11] == base);
  // only the low 512 bytes of the region hold registers
  assign in_window = in_region && (acc.addr[10:9] == 2'b00);

  always_comb begin
    st_d            = st_q;
    st_d.win.hit    = in_window;
    // the rest of the region goes on to memory decode
    st_d.win.mem    = acc.valid && !in_window;
    st_d.win.offset = acc.addr[8:0];
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign win = st_q.win;

  chk_win_hit_decode: assert property (@(posedge core_clk) disable iff (!rstn)
    acc.valid && acc.addr[15:11] == base && acc.addr[10:9] == 2'b00
      |=> win.hit && !win.mem)
    else $error("window access not decoded as hit");
  chk_win_upper_falls: assert property (@(posedge core_clk) disable iff (!rstn)
    acc.valid && acc.addr[10:9] != 2'b00 |=> !win.hit && win.mem)
    else $error("offset past 511 selected the window");

endmodule // pfpc_win_dec

/* pfpc_top.sv */
// port function assignment, pad control and register window
//
// Overview of operation
// - low byte strobe is XNOR of address bit 0 and access size flag
// - bus clock derived from clock input at half its rate
// - mode pins carry queue tracking or general I/O, software chosen
// - ports A,B general I/O single-chip; address high/low when expanded
// - port C I/O single-chip; data high wide; both bytes narrow
// - port D I/O single-chip and narrow; data low byte in wide
// - two lowest port E pins are input only; direction writes ignored
// - enabled port D or H input falling edge raises key wakeup
// - enabled port J input change either way raises key wakeup
// - pullups A-H enabled at reset per bit; irq pullup always; mode pulldowns
// - each port J pin selects pullup or pulldown by software
// - after reset port J selects pulldowns, all disabled
// - register window placed on any 2-Kbyte boundary by base field
// - base field compared with top five bits of the 16-bit address
// - registers decoded only in the first 512 bytes of region
//
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/1ps
module pfpc_top
  import pfpc_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rstn,
  // avalon-mm register slave
  input  wire logic [9:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [3:0]  avs_byteenable,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // core bus access
  input  wire pfpc_acc_t   cpu_acc,
  input  wire logic        access_size_flag,
  input  wire logic        bus_write,
  input  wire logic [15:0] bus_wdata,
  input  wire logic        queue_track_0,
  input  wire logic        queue_track_1,
  output pfpc_win_t        win,
  // general-purpose port drive from port logic
  input  wire pfpc_pad_t   gpio_a,
  input  wire pfpc_pad_t   gpio_b,
  input  wire pfpc_pad_t   gpio_c,
  input  wire pfpc_pad_t   gpio_d,
  input  wire pfpc_pad_t   gpio_e,
  // pad drive
  output pfpc_pad_t        pad_a,
  output pfpc_pad_t        pad_b,
  output pfpc_pad_t        pad_c,
  output pfpc_pad_t        pad_d,
  output pfpc_pad_t        pad_e,
  output logic             low_byte_strobe,
  output logic             bus_clk,
  // key wakeup pin inputs
  input  wire logic [7:0]  pin_d_i,
  input  wire logic [7:0]  pin_h_i,
  input  wire logic [7:0]  pin_j_i,
  output logic             key_wakeup_irq,
  // pad loads and drive strength
  output logic [7:0]       pullup_en,
  output logic             maskable_irq_pin_pullup,
  output logic             mode_pulldown_en,
  output logic [7:0]       port_j_pullup_en,
  output logic [7:0]       port_j_pulldown_en,
  output logic [7:0]       drive_strength
);

  typedef struct packed {
    logic        ack;
    logic [7:0]  rdata;
    logic [7:0]  pu;
    logic [7:0]  drv;
    logic [7:0]  jsel;
    logic [7:0]  jen;
    logic [4:0]  base;
    logic [2:0]  mode;
    logic [23:0] kwe;
    logic [23:0] kwf;
    logic [23:0] s1;
    logic [23:0] s2;
    logic [23:0] s3;
    logic [23:0] filt;
    logic        eclk;
    logic        in_rst;
  } pfpc_st_t;

  pfpc_st_t    st_q;
  pfpc_st_t    st_d;
  logic [7:0]  idx;
  logic        wr_now;
  logic        rd_take;
  logic        exp_m;
  logic        wide_m;
  logic        qt_en;
  logic [23:0] fall;
  logic [23:0] rise;
  logic [23:0] filt_d;
  logic [23:0] kw_ev;
  logic [7:0]  rd_mux;
  logic        strobe;

  assign idx     = avs_address[9:2];
  assign exp_m   = st_q.mode[MODE_EXPANDED];
  assign wide_m  = st_q.mode[MODE_WIDE];
  assign qt_en   = st_q.mode[MODE_QTRACK];
  // write lands only on the edge where waitrequest is low
  assign wr_now  = avs_write && st_q.ack && avs_byteenable[0];
  assign rd_take = (avs_read || avs_write) && !st_q.ack;

  // one wait state: the answer is ready on the second request cycle
  assign avs_waitrequest = (avs_read || avs_write) && !st_q.ack;
  assign avs_readdata    = {24'h000000, st_q.rdata};

  // read multiplexer; unmapped indices read as zero
  always_comb begin
    rd_mux = 8'h00;
    unique case (idx)
      IDX_PULLUP_EN:  rd_mux = st_q.pu;
      IDX_DRIVE_STR:  rd_mux = st_q.drv;
      IDX_WIN_BASE:   rd_mux = {st_q.base, 3'h0};
      IDX_J_PULL_SEL: rd_mux = st_q.jsel;
      IDX_J_PULL_EN:  rd_mux = st_q.jen;
      IDX_MODE_CTRL:  rd_mux = {5'h00, st_q.mode};
      IDX_KWU_EN_D:   rd_mux = st_q.kwe[7:0];
      IDX_KWU_EN_H:   rd_mux = st_q.kwe[15:8];
      IDX_KWU_EN_J:   rd_mux = st_q.kwe[23:16];
      IDX_KWU_FLAG_D: rd_mux = st_q.kwf[7:0];
      IDX_KWU_FLAG_H: rd_mux = st_q.kwf[15:8];
      IDX_KWU_FLAG_J: rd_mux = st_q.kwf[23:16];
      default:        rd_mux = 8'h00;
    endcase
  end

  // filter: a level counts once stages two and three agree; kept apart
  // from the main next-state process so the edge terms form no loop
  always_comb begin
    filt_d = st_q.filt;
    for (int i = 0; i < 24; i++) begin
      if (st_q.s2[i] == st_q.s3[i]) begin
        filt_d[i] = st_q.s3[i];
      end
    end
  end

  // filtered pin edges; d and h wake on falls, j on any change
  assign fall  = st_q.filt & ~filt_d;
  assign rise  = ~st_q.filt & filt_d;
  assign kw_ev = {(fall[23:16] | rise[23:16]), fall[15:0]} & st_q.kwe;

  // next-state logic for the whole block
  always_comb begin
    st_d        = st_q;
    st_d.ack    = rd_take;
    st_d.in_rst = 1'b0;
    st_d.eclk   = !st_q.eclk;
    if (rd_take) begin
      st_d.rdata = rd_mux;
    end
    // three-stage sampling of the asynchronous pins
    st_d.s1   = {pin_j_i, pin_h_i, pin_d_i};
    st_d.s2   = st_q.s1;
    st_d.s3   = st_q.s2;
    st_d.filt = filt_d;
    // sticky wakeup flags: a new event beats a same-cycle clear
    st_d.kwf = st_q.kwf | kw_ev;
    if (wr_now) begin
      unique case (idx)
        IDX_PULLUP_EN:  st_d.pu   = avs_writedata[7:0];
        IDX_DRIVE_STR:  st_d.drv  = avs_writedata[7:0];
        IDX_WIN_BASE:   st_d.base = avs_writedata[7:WIN_FIELD_LSB];
        IDX_J_PULL_SEL: st_d.jsel = avs_writedata[7:0];
        IDX_J_PULL_EN:  st_d.jen  = avs_writedata[7:0];
        IDX_MODE_CTRL:  st_d.mode = avs_writedata[2:0];
        IDX_KWU_EN_D:   st_d.kwe[7:0]   = avs_writedata[7:0];
        IDX_KWU_EN_H:   st_d.kwe[15:8]  = avs_writedata[7:0];
        IDX_KWU_EN_J:   st_d.kwe[23:16] = avs_writedata[7:0];
        IDX_KWU_FLAG_D: st_d.kwf[7:0] =
          (st_q.kwf[7:0] & ~avs_writedata[7:0]) | kw_ev[7:0];
        IDX_KWU_FLAG_H: st_d.kwf[15:8] =
          (st_q.kwf[15:8] & ~avs_writedata[7:0]) | kw_ev[15:8];
        IDX_KWU_FLAG_J: st_d.kwf[23:16] =
          (st_q.kwf[23:16] & ~avs_writedata[7:0]) | kw_ev[23:16];
        default: ;
      endcase
    end
  end

  // filt reset high: pins idle high behind their pullups
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_q        <= '0;
      st_q.pu     <= RST_PULLUP_EN;
      st_q.drv    <= RST_DRIVE_STR;
      st_q.jsel   <= RST_J_PULL_SEL;
      st_q.jen    <= RST_J_PULL_EN;
      st_q.base   <= RST_WIN_BASE;
      st_q.mode   <= RST_MODE_CTRL;
      st_q.s1     <= 24'hffffff;
      st_q.s2     <= 24'hffffff;
      st_q.s3     <= 24'hffffff;
      st_q.filt   <= 24'hffffff;
      st_q.in_rst <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // register window decoder
  pfpc_win_dec u_win_dec (
    .core_clk (core_clk),
    .rstn     (rstn),
    .base     (st_q.base),
    .acc      (cpu_acc),
    .win      (win)
  );

  // strobe low marks a valid low byte
  assign strobe          = !(cpu_acc.addr[0] ^ access_size_flag);
  assign low_byte_strobe = strobe;
  assign bus_clk         = st_q.eclk;

  // address ports: general i/o only in single-chip modes
  always_comb begin
    pad_a = gpio_a;
    pad_b = gpio_b;
    if (exp_m) begin
      pad_a.o  = cpu_acc.addr[15:8];
      pad_a.oe = 8'hff;
      pad_b.o  = cpu_acc.addr[7:0];
      pad_b.oe = 8'hff;
    end
  end

  // data ports; narrow mode moves both bytes over port c in turn
  always_comb begin
    pad_c = gpio_c;
    pad_d = gpio_d;
    if (exp_m && wide_m) begin
      pad_c.o  = bus_wdata[15:8];
      pad_c.oe = {8{bus_write}};
      pad_d.o  = bus_wdata[7:0];
      pad_d.oe = {8{bus_write}};
    end else if (exp_m) begin
      pad_c.o  = cpu_acc.addr[0] ? bus_wdata[7:0] : bus_wdata[15:8];
      pad_c.oe = {8{bus_write}};
    end
  end

  // port e: interrupt pins never drive, whatever the direction bits say
  always_comb begin
    pad_e = gpio_e;
    if (exp_m) begin
      pad_e.o[PE_STROBE]  = strobe;
      pad_e.oe[PE_STROBE] = 1'b1;
      pad_e.o[PE_BCLK]    = st_q.eclk;
      pad_e.oe[PE_BCLK]   = 1'b1;
    end
    if (qt_en) begin
      pad_e.o[PE_MODE_A]  = queue_track_0;
      pad_e.o[PE_MODE_B]  = queue_track_1;
      pad_e.oe[PE_MODE_A] = 1'b1;
      pad_e.oe[PE_MODE_B] = 1'b1;
    end
    pad_e.oe[PE_MI]  = 1'b0;
    pad_e.oe[PE_NMI] = 1'b0;
  end

  // loads: mode pins pulled down while reset is applied and until the first clock edge after release
  assign pullup_en               = st_q.pu;
  assign maskable_irq_pin_pullup = 1'b1;
  assign mode_pulldown_en        = st_q.in_rst;
  assign port_j_pullup_en        = st_q.jen & st_q.jsel;
  assign port_j_pulldown_en      = st_q.jen & ~st_q.jsel;
  assign drive_strength          = st_q.drv;
  assign key_wakeup_irq          = |(st_q.kwf & st_q.kwe);

  // checks
  sequence s_req_wait;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_req_done;
    (avs_read || avs_write) && !avs_waitrequest;
  endsequence

  chk_bus_one_wait: assert property (@(posedge core_clk) disable iff (!rstn)
    s_req_wait |=> s_req_done or !(avs_read || avs_write))
    else $error("slave took more than one wait state");
  chk_strobe_xnor: assert property (@(posedge core_clk) disable iff (!rstn)
    low_byte_strobe == (cpu_acc.addr[0] ~^ access_size_flag))
    else $error("low byte strobe wrong");
  chk_bus_clk_half: assert property (@(posedge core_clk) disable iff (!rstn)
    bus_clk |=> !bus_clk ##1 bus_clk)
    else $error("bus clock not half rate");
  chk_qtrack_route: assert property (@(posedge core_clk) disable iff (!rstn)
    qt_en |-> pad_e.o[PE_MODE_A] == queue_track_0
      && pad_e.oe[PE_MODE_B])
    else $error("queue tracking not routed");
  chk_addr_ports: assert property (@(posedge core_clk) disable iff (!rstn)
    exp_m |-> pad_a.o == cpu_acc.addr[15:8]
      && pad_b.o == cpu_acc.addr[7:0])
    else $error("address not on ports a and b");
  chk_single_gpio: assert property (@(posedge core_clk) disable iff (!rstn)
    !exp_m |-> pad_a == gpio_a && pad_c == gpio_c)
    else $error("single-chip port not general i/o");
  chk_narrow_port_d: assert property (@(posedge core_clk) disable iff (!rstn)
    exp_m && !wide_m |-> pad_d == gpio_d
      && pad_c.o == (cpu_acc.addr[0] ? bus_wdata[7:0]
                                     : bus_wdata[15:8]))
    else $error("narrow mode data routing wrong");
  chk_wide_port_d: assert property (@(posedge core_clk) disable iff (!rstn)
    exp_m && wide_m |-> pad_d.o == bus_wdata[7:0])
    else $error("wide mode low data byte not on port d");
  chk_irq_pins_input: assert property (@(posedge core_clk) disable iff (!rstn)
    pad_e.oe[1:0] == 2'b00)
    else $error("interrupt pin driven");
  chk_kwu_d_fall: assert property (@(posedge core_clk) disable iff (!rstn)
    st_q.kwe[0] && $fell(st_q.filt[0]) |-> st_q.kwf[0]
      ##0 key_wakeup_irq)
    else $error("port d fall did not flag wakeup");
  chk_kwu_j_rise: assert property (@(posedge core_clk) disable iff (!rstn)
    st_q.kwe[16] && $rose(st_q.filt[16]) |-> st_q.kwf[16])
    else $error("port j rise did not flag wakeup");
  chk_reset_pullups: assert property (@(posedge core_clk)
    $rose(rstn) |-> pullup_en == RST_PULLUP_EN
      && port_j_pullup_en == 8'h00 && port_j_pulldown_en == 8'h00
      && mode_pulldown_en)
    else $error("pad loads wrong at reset release");
  chk_j_pull_split: assert property (@(posedge core_clk) disable iff (!rstn)
    (port_j_pullup_en & port_j_pulldown_en) == 8'h00
      && (port_j_pullup_en | port_j_pulldown_en) == st_q.jen)
    else $error("port j pull selection wrong");
  chk_base_write: assert property (@(posedge core_clk) disable iff (!rstn)
    wr_now && idx == IDX_WIN_BASE
      |=> st_q.base == $past(avs_writedata[7:3]))
    else $error("window base not written");

endmodule // pfpc_top

/* pfpc_board_model.sv */
// board-side model: key wakeup pin levels and external word store
`timescale 1ns/1ps
module pfpc_board_model
  import pfpc_pkg::*;
(
  // clock
  input  wire logic      core_clk,
  // expansion bus pads
  input  wire pfpc_pad_t pad_b,
  input  wire pfpc_pad_t pad_c,
  input  wire pfpc_pad_t pad_d,
  // key wakeup pin levels
  output logic [7:0]     pin_d,
  output logic [7:0]     pin_h,
  output logic [7:0]     pin_j
);
  logic [15:0] mem [256];

  // pins rest high: board pullups hold them when nothing pulls
  initial begin
    pin_d = 8'hff;
    pin_h = 8'hff;
    pin_j = 8'hff;
  end

  // change pin levels just after an edge
  task automatic set_pins(input logic [7:0] d, h, j);
    pin_d <= d;
    pin_h <= h;
    pin_j <= j;
  endtask

  // word store: a word is taken only while both data bytes are driven
  always @(posedge core_clk) begin
    if (pad_c.oe == 8'hff && pad_d.oe == 8'hff)
      mem[pad_b.o] <= {pad_c.o, pad_d.o};
  end
endmodule // pfpc_board_model

/* pfpc_top_tb.sv */
// self-checking bench for port function and pad control
`timescale 1ns/1ps
module pfpc_top_tb;
  import pfpc_pkg::*;
  logic        core_clk, rstn, avs_read, avs_write, avs_waitrequest;
  logic [9:0]  avs_address;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata;
  pfpc_acc_t   cpu_acc;
  logic        access_size_flag, bus_write, qt0, qt1, bclk;
  logic [15:0] bus_wdata, a;
  pfpc_win_t   win;
  pfpc_pad_t   gpio_a, gpio_b, gpio_c, gpio_d, gpio_e;
  pfpc_pad_t   pad_a, pad_b, pad_c, pad_d, pad_e;
  logic        low_byte_strobe, bus_clk, key_wakeup_irq, mi_pu, mode_pd;
  logic [7:0]  pin_d, pin_h, pin_j, pullup_en, j_pu, j_pd, drive, d, js;
  logic [2:0]  m;
  logic [4:0]  b;
  int          bad_count, num_checks, r;
  logic [31:0] rq[$];
  pfpc_win_t   wq[$];
  event        win_ev;

  pfpc_top u_pfpc_top (.core_clk(core_clk), .rstn(rstn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .cpu_acc(cpu_acc), .access_size_flag(access_size_flag),
    .bus_write(bus_write), .bus_wdata(bus_wdata), .queue_track_0(qt0),
    .queue_track_1(qt1), .win(win), .gpio_a(gpio_a), .gpio_b(gpio_b),
    .gpio_c(gpio_c), .gpio_d(gpio_d), .gpio_e(gpio_e), .pad_a(pad_a),
    .pad_b(pad_b), .pad_c(pad_c), .pad_d(pad_d), .pad_e(pad_e),
    .low_byte_strobe(low_byte_strobe), .bus_clk(bus_clk), .pin_d_i(pin_d),
    .pin_h_i(pin_h), .pin_j_i(pin_j), .key_wakeup_irq(key_wakeup_irq),
    .pullup_en(pullup_en), .maskable_irq_pin_pullup(mi_pu),
    .mode_pulldown_en(mode_pd), .port_j_pullup_en(j_pu),
    .port_j_pulldown_en(j_pd), .drive_strength(drive));

  pfpc_board_model u_pfpc_board_model (.core_clk(core_clk), .pad_b(pad_b),
    .pad_c(pad_c), .pad_d(pad_d), .pin_d(pin_d), .pin_h(pin_h),
    .pin_j(pin_j));

  // 200 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("checks=%0d mismatches=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // one avalon transfer, held until waitrequest is sampled low at an edge
  task automatic bus_req(input logic [7:0] idx, input logic wr,
                         input logic [7:0] dat, input logic [3:0] be);
    @(posedge core_clk);
    avs_address <= {idx, 2'b00};
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= {24'h0, dat};
    avs_byteenable <= be;
    @(posedge core_clk);
    while (avs_waitrequest) @(posedge core_clk);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] dat);
    bus_req(idx, 1'b1, dat, 4'h1);
  endtask

  // note the expected byte, then read it
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    rq.push_back({24'h0, exp});
    bus_req(idx, 1'b0, 8'h00, 4'h1);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask

  // read results are taken at the edge where waitrequest is seen low
  always @(posedge core_clk) begin
    if (avs_read && !avs_waitrequest && rq.size() > 0)
      check(avs_readdata, rq.pop_front());
  end

  always @(win_ev) check(win, wq.pop_front());

  // hang guard, well beyond the few hundred cycles used
  initial begin
    #200000;
    bad_count++;
    test_done();
  end

  initial begin
    {rstn, avs_read, avs_write, avs_address, avs_byteenable} = '0;
    {avs_writedata, cpu_acc, access_size_flag, bus_write, bus_wdata} = '0;
    {qt0, qt1, gpio_a, gpio_b, gpio_c, gpio_d, gpio_e} = '0;
    r = $urandom(32'h36d89d00);
    settle(8);
    check(pullup_en, 8'hff);
    check(mode_pd, 1'b1);
    @(posedge core_clk);
    rstn <= 1'b1;
    settle(2);
    check(mode_pd, 1'b0);
    check(mi_pu, 1'b1);
    check({j_pu, j_pd}, 16'h0000);
    rd(IDX_PULLUP_EN, RST_PULLUP_EN);
    rd(IDX_DRIVE_STR, RST_DRIVE_STR);
    rd(IDX_J_PULL_SEL, RST_J_PULL_SEL);
    rd(IDX_J_PULL_EN, RST_J_PULL_EN);
    rd(IDX_WIN_BASE, 8'h00);
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      bclk = bus_clk;
      @(negedge core_clk);
      check(bus_clk, !bclk);
    end
    $display("bus clock test done");
    d = 8'($urandom);
    wr(IDX_PULLUP_EN, d);
    rd(IDX_PULLUP_EN, d);
    check(pullup_en, d);
    js = 8'($urandom);
    wr(IDX_J_PULL_SEL, js);
    rd(IDX_J_PULL_SEL, js);
    d = 8'($urandom);
    wr(IDX_J_PULL_EN, d);
    rd(IDX_J_PULL_EN, d);
    check({j_pu, j_pd}, {d & js, d & ~js});
    wr(IDX_DRIVE_STR, d);
    bus_req(IDX_DRIVE_STR, 1'b1, ~d, 4'h0);
    rd(IDX_DRIVE_STR, d);
    check(drive, d);
    wr(8'h01, 8'hff);
    rd(8'h01, 8'h00);
    $display("register test done");
    for (int k = 0; k < 4; k++) begin
      @(posedge core_clk);
      cpu_acc.addr <= {14'h0, k[0], 1'b0} | 16'(k[0]);
      access_size_flag <= k[1];
      @(negedge core_clk);
      check(low_byte_strobe, !(k[0] ^ k[1]));
    end
    $display("strobe test done");
    for (int i = 0; i < 8; i++) begin
      m = 3'(i);
      wr(IDX_MODE_CTRL, {5'h1f, m});
      rd(IDX_MODE_CTRL, {5'h00, m});
      a = 16'($urandom);
      @(posedge core_clk);
      cpu_acc <= {1'b1, a};
      access_size_flag <= 1'($urandom);
      bus_write <= (m == 3'd3) ? 1'b1 : 1'($urandom);
      bus_wdata <= 16'($urandom);
      {qt0, qt1} <= 2'($urandom);
      gpio_a <= 16'($urandom);
      gpio_b <= 16'($urandom);
      gpio_c <= 16'($urandom);
      gpio_d <= 16'($urandom);
      gpio_e <= 16'($urandom) | 16'h0003;
      @(negedge core_clk);
      check(pad_a, m[0] ? {a[15:8], 8'hff} : gpio_a);
      check(pad_b, m[0] ? {a[7:0], 8'hff} : gpio_b);
      check(pad_c, !m[0] ? gpio_c : m[1] ? {bus_wdata[15:8], {8{bus_write}}}
        : {a[0] ? bus_wdata[7:0] : bus_wdata[15:8], {8{bus_write}}});
      check(pad_d, (m[0] && m[1]) ? {bus_wdata[7:0], {8{bus_write}}}
        : gpio_d);
      check(pad_e.oe[1:0], 2'b00);
      if (m[2])
        check({pad_e.o[6:5], pad_e.oe[6:5]}, {qt1, qt0, 2'b11});
      if (m[0])
        check({pad_e.o[3], pad_e.oe[3]},
              {~(a[0] ^ access_size_flag), 1'b1});
      if (m[0])
        check({pad_e.o[4], pad_e.oe[4]}, {bus_clk, 1'b1});
      if (m == 3'd3) begin
        settle(1);
        check(u_pfpc_board_model.mem[a[7:0]], bus_wdata);
      end
    end
    $display("port function test done");
    b = 5'($urandom);
    wr(IDX_WIN_BASE, {b, 3'b111});
    rd(IDX_WIN_BASE, {b, 3'b000});
    for (int i = 0; i < 6; i++) begin
      a = {(i == 4) ? b + 5'h01 : b, 11'h0} | 16'(i < 4 ? i * 511 : 1);
      if (i == 3) a[10:0] = 11'h7ff;
      wq.push_back({i != 5 && i < 2, i != 5 && i >= 2, a[8:0]});
      @(posedge core_clk);
      cpu_acc <= {i != 5, a};
      settle(1);
      -> win_ev;
    end
    $display("window test done");
    wr(IDX_KWU_EN_D, 8'h01);
    wr(IDX_KWU_EN_H, 8'h02);
    wr(IDX_KWU_EN_J, 8'h81);
    u_pfpc_board_model.set_pins(8'hfe, 8'hff, 8'hff);
    settle(8);
    check(key_wakeup_irq, 1'b1);
    rd(IDX_KWU_FLAG_D, 8'h01);
    wr(IDX_KWU_FLAG_D, 8'h01);
    u_pfpc_board_model.set_pins(8'hff, 8'hfc, 8'hff);
    settle(8);
    rd(IDX_KWU_FLAG_D, 8'h00);
    rd(IDX_KWU_FLAG_H, 8'h02);
    wr(IDX_KWU_FLAG_H, 8'hff);
    settle(1);
    check(key_wakeup_irq, 1'b0);
    for (int i = 0; i < 2; i++) begin
      u_pfpc_board_model.set_pins(8'hff, 8'hfc, i ? 8'hff : 8'h7e);
      settle(8);
      check(key_wakeup_irq, 1'b1);
      rd(IDX_KWU_FLAG_J, 8'h81);
      wr(IDX_KWU_FLAG_J, 8'h81);
    end
    $display("key wakeup test done");
    test_done();
  end
endmodule // pfpc_top_tb
